// ===== verilog/lmc_ctrl.sv
/*
  Mode control of a single-wire bus transceiver with regulator.
  Assumes the bus line and analog comparator flags are synchronous to clk_sys_in; host pins pass through two-flop synchronisers.
*/
`timescale 1ns/1ns
module lmc_ctrl #(
  parameter int unsigned DOM_LIMIT_CYC = lmc_pkg::LMC_DOM_LIMIT_CYC,
  parameter int unsigned DOM_CLEAR_CYC = lmc_pkg::LMC_DOM_CLEAR_CYC,
  parameter int unsigned WAKE_FILT_CYC = lmc_pkg::LMC_WAKE_FILT_CYC,
  parameter int unsigned RST_DELAY_CYC = lmc_pkg::LMC_RST_DELAY_CYC
) (
  // Clock and power-up reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Host side
  input wire logic mode_sel_in,
  input wire logic txd_in,
  output logic rxd_out,
  output logic supply_fail_reset_out,
  // Bus side
  input wire logic bus_dominant_in,
  output logic bus_drive_out,
  output logic termination_on_out,
  // Analog monitors and regulator
  input wire logic vcc_under_in,
  input wire logic battery_supply_low_in,
  output logic regulator_on_out,
  output logic dom_timeout_out,
  output lmc_pkg::lmc_mode_t mode_out
);
  // ==========================================================
  // Input synchronisers
  logic [1:0] en_sync_q;
  logic [1:0] tx_sync_q;
  logic en_prev_q;
  logic bus_prev_q;
  logic en_s;
  logic tx_s;
  logic en_fall;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      en_sync_q <= 2'h0;
      tx_sync_q <= 2'h3;
      en_prev_q <= 1'b0;
      bus_prev_q <= 1'b0;
    end else begin
      en_sync_q <= {en_sync_q[0], mode_sel_in};
      tx_sync_q <= {tx_sync_q[0], txd_in};
      en_prev_q <= en_sync_q[1];
      bus_prev_q <= bus_dominant_in;
    end
  end

  assign en_s = en_sync_q[1];
  assign tx_s = tx_sync_q[1];
  assign en_fall = en_prev_q && !en_s;

  // ==========================================================
  // Timers
  logic dom_done;
  logic clr_done;
  logic wake_done;
  logic rst_done;
  logic wake_arm_q;
  logic rst_hold_q;
  logic [2:0] fall_cnt_q;

  lmc_timer #(.LIMIT(DOM_LIMIT_CYC), .W(24)) u_dom (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .run_in(!tx_s && !dom_timeout_out),
    .done_out(dom_done)
  );
  lmc_timer #(.LIMIT(DOM_CLEAR_CYC), .W(24)) u_clr (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .run_in(tx_s && dom_timeout_out),
    .done_out(clr_done)
  );
  lmc_timer #(.LIMIT(WAKE_FILT_CYC), .W(24)) u_wake (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .run_in(wake_arm_q && bus_dominant_in),
    .done_out(wake_done)
  );
  lmc_timer #(.LIMIT(RST_DELAY_CYC), .W(24)) u_rst (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .run_in(rst_hold_q && !vcc_under_in && regulator_on_out),
    .done_out(rst_done)
  );

  // Wake arming needs a fresh falling edge, so a stuck bus never wakes
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wake_arm_q <= 1'b0;
    end else if (mode_out != lmc_pkg::LMC_SILENT &&
                 mode_out != lmc_pkg::LMC_SLEEP) begin
      wake_arm_q <= 1'b0;
    end else if (bus_dominant_in && !bus_prev_q) begin
      wake_arm_q <= 1'b1;
    end else if (!bus_dominant_in) begin
      wake_arm_q <= 1'b0;
    end
  end

  // ==========================================================
  // Dominant time-out
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      dom_timeout_out <= 1'b0;
    end else if (dom_done) begin
      dom_timeout_out <= 1'b1;
    end else if (clr_done) begin
      dom_timeout_out <= 1'b0;
    end
  end

  // ==========================================================
  // Undervoltage reset output
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || !vcc_under_in || !regulator_on_out) begin
      fall_cnt_q <= 3'h0;
    end else if (fall_cnt_q != 3'(lmc_pkg::LMC_RST_FALL_CYC)) begin
      fall_cnt_q <= fall_cnt_q + 3'h1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rst_hold_q <= 1'b1;
      supply_fail_reset_out <= 1'b0;
    end else if (mode_out == lmc_pkg::LMC_SLEEP) begin
      rst_hold_q <= 1'b1;
      supply_fail_reset_out <= 1'b0;
    end else if (fall_cnt_q == 3'(lmc_pkg::LMC_RST_FALL_CYC)) begin
      rst_hold_q <= 1'b1;
      supply_fail_reset_out <= 1'b0;
    end else if (rst_done) begin
      rst_hold_q <= 1'b0;
      supply_fail_reset_out <= 1'b1;
    end
  end

  // ==========================================================
  // Mode state machine
  // Supply loss and wake-up outrank the hold; the hold outranks the host
  lmc_pkg::lmc_mode_t mode_d;
  logic uv_reset;
  logic wake_flag_q;

  function automatic logic quiet_mode(input lmc_pkg::lmc_mode_t m);
    return (m == lmc_pkg::LMC_SILENT) || (m == lmc_pkg::LMC_SLEEP);
  endfunction

  if (DOM_LIMIT_CYC < 1 || DOM_CLEAR_CYC < 1 ||
      WAKE_FILT_CYC < 1 || RST_DELAY_CYC < 1) begin : g_bad_count
    $error("lmc_ctrl counts must be at least one cycle");
  end

  assign uv_reset = (fall_cnt_q == 3'(lmc_pkg::LMC_RST_FALL_CYC));

  always_comb begin
    mode_d = mode_out;
    unique case (mode_out)
      lmc_pkg::LMC_SLEEP: begin
        if (wake_done) begin
          mode_d = lmc_pkg::LMC_PRENORMAL;
        end
      end
      lmc_pkg::LMC_SILENT: begin
        if (uv_reset) begin
          mode_d = lmc_pkg::LMC_PRENORMAL;
        end else if (wake_done) begin
          mode_d = lmc_pkg::LMC_PRENORMAL;
        end else if (!rst_hold_q && en_s) begin
          mode_d = lmc_pkg::LMC_NORMAL;
        end
      end
      lmc_pkg::LMC_NORMAL: begin
        if (uv_reset) begin
          mode_d = lmc_pkg::LMC_PRENORMAL;
        end else if (en_fall && tx_s) begin
          mode_d = lmc_pkg::LMC_SILENT;
        end else if (en_fall) begin
          mode_d = lmc_pkg::LMC_SLEEP;
        end
      end
      lmc_pkg::LMC_PRENORMAL: begin
        // Host requests wait until the reset output is released
        if (!rst_hold_q && en_s) begin
          mode_d = lmc_pkg::LMC_NORMAL;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      mode_out <= lmc_pkg::LMC_PRENORMAL;
    end else begin
      mode_out <= mode_d;
    end
  end

  // Wake indication stays until the mode is back in Normal
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wake_flag_q <= 1'b0;
    end else if (wake_done && quiet_mode(mode_out)) begin
      wake_flag_q <= 1'b1;
    end else if (mode_out == lmc_pkg::LMC_NORMAL) begin
      wake_flag_q <= 1'b0;
    end
  end

  // ==========================================================
  // Pin outputs
  // Every gate is registered, so the driver lags its causes by one cycle
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      bus_drive_out <= 1'b0;
    end else begin
      bus_drive_out <= (mode_out == lmc_pkg::LMC_NORMAL) && !tx_s &&
                       !dom_timeout_out && !battery_supply_low_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rxd_out <= 1'b1;
    end else if (mode_out == lmc_pkg::LMC_SLEEP || wake_flag_q) begin
      rxd_out <= 1'b0;
    end else begin
      rxd_out <= !bus_dominant_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      termination_on_out <= 1'b1;
    end else begin
      termination_on_out <= !quiet_mode(mode_out);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      regulator_on_out <= 1'b1;
    end else begin
      regulator_on_out <= (mode_out != lmc_pkg::LMC_SLEEP);
    end
  end

  // ==========================================================
  // Assertions
  property p_drive_normal;
    @(posedge clk_sys_in) disable iff (rst_in)
      bus_drive_out |-> ($past(mode_out) == lmc_pkg::LMC_NORMAL);
  endproperty
  a_drive_normal: assert property (p_drive_normal)
    else $error("bus driven outside Normal mode");

  property p_drive_tx;
    @(posedge clk_sys_in) disable iff (rst_in)
      bus_drive_out |-> !$past(tx_s);
  endproperty
  a_drive_tx: assert property (p_drive_tx)
    else $error("bus driven while transmit input high");

  property p_drive_timeout;
    @(posedge clk_sys_in) disable iff (rst_in)
      bus_drive_out |-> !$past(dom_timeout_out);
  endproperty
  a_drive_timeout: assert property (p_drive_timeout)
    else $error("bus driven during dominant time-out");

  property p_drive_batt;
    @(posedge clk_sys_in) disable iff (rst_in)
      bus_drive_out |-> !$past(battery_supply_low_in);
  endproperty
  a_drive_batt: assert property (p_drive_batt)
    else $error("bus driven with battery supply low");

  property p_rx_follow;
    @(posedge clk_sys_in) disable iff (rst_in)
      ($past(mode_out) != lmc_pkg::LMC_SLEEP && !$past(wake_flag_q)) |->
        (rxd_out == !$past(bus_dominant_in));
  endproperty
  a_rx_follow: assert property (p_rx_follow)
    else $error("receive output does not follow the bus");

  property p_sleep_outs;
    @(posedge clk_sys_in) disable iff (rst_in)
      (mode_out == lmc_pkg::LMC_SLEEP &&
       $past(mode_out) == lmc_pkg::LMC_SLEEP) |->
        (!regulator_on_out && !rxd_out && !supply_fail_reset_out);
  endproperty
  a_sleep_outs: assert property (p_sleep_outs)
    else $error("sleep outputs not low");

  property p_silent_term;
    @(posedge clk_sys_in) disable iff (rst_in)
      (mode_out == lmc_pkg::LMC_SILENT &&
       $past(mode_out) == lmc_pkg::LMC_SILENT) |-> !termination_on_out;
  endproperty
  a_silent_term: assert property (p_silent_term)
    else $error("termination on in Silent mode");

  property p_hold_mode;
    @(posedge clk_sys_in) disable iff (rst_in)
      ($past(rst_hold_q) &&
       $past(mode_out) == lmc_pkg::LMC_PRENORMAL) |->
        (mode_out == lmc_pkg::LMC_PRENORMAL);
  endproperty
  a_hold_mode: assert property (p_hold_mode)
    else $error("mode changed during reset hold");

  property p_uv_prenormal;
    @(posedge clk_sys_in) disable iff (rst_in)
      (uv_reset && (mode_out == lmc_pkg::LMC_NORMAL ||
                    mode_out == lmc_pkg::LMC_SILENT)) |=>
        (mode_out == lmc_pkg::LMC_PRENORMAL && !supply_fail_reset_out);
  endproperty
  a_uv_prenormal: assert property (p_uv_prenormal)
    else $error("undervoltage did not force Pre-normal");

  c_enter_silent: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    $past(mode_out) == lmc_pkg::LMC_NORMAL &&
    mode_out == lmc_pkg::LMC_SILENT);
  c_enter_sleep: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    $past(mode_out) == lmc_pkg::LMC_NORMAL &&
    mode_out == lmc_pkg::LMC_SLEEP);
  c_wake_silent: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    $past(mode_out) == lmc_pkg::LMC_SILENT &&
    mode_out == lmc_pkg::LMC_PRENORMAL);
  c_dom_timeout: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    $rose(dom_timeout_out));
endmodule

// ===== verilog/lmc_pkg.sv
/*
  Constants of the bus transceiver mode control: modes and timing counts.
  Assumes a 125 MHz system clock standing in for the internal oscillator.

  // Summary of operation
  // - After battery power-up the device enters Pre-normal whatever mode-select shows.
  // - Mode-select high gives Normal mode; from Silent it goes straight to Normal.
  // - Mode-select falling edge with transmit input high enters Silent mode.
  // - Mode-select falling edge with transmit input low enters Sleep mode.
  // - Bus driven dominant only while transmit input is low; otherwise recessive.
  // - Transmit low beyond 4 ms forces the driver recessive: dominant time-out.
  // - Time-out clears only after transmit input is high more than 10 us.
  // - Receive output follows the bus: high recessive, low dominant.
  // - Regulator undervoltage pulls reset output low after a short delay.
  // - Reset output stays low 10 ms after regulator reaches nominal.
  // - Undervoltage in Normal or Silent drives reset low and enters Pre-normal.
  // - Silent disables transmit and switches the slave termination off.
  // - Falling bus edge then dominant for 90 us is a remote wake-up.
  // - Wake-up from Silent enters Pre-normal, termination on, receive output low.
  // - Battery supply below 5 V inhibits bus transmission.
  // - Pre-normal keeps bus communication off, undervoltage detection active.
  // - While reset output is held low, mode change requests are ignored.
  // - Sleep: regulator off, reset and receive low; bus wake-up gives Pre-normal.
*/
package lmc_pkg;
  typedef enum logic [1:0] {
    LMC_PRENORMAL,
    LMC_NORMAL,
    LMC_SILENT,
    LMC_SLEEP
  } lmc_mode_t;

  localparam int unsigned LMC_CLK_MHZ = 125;
  localparam int unsigned LMC_DOM_LIMIT_US = 4000;
  localparam int unsigned LMC_DOM_CLEAR_US = 10;
  localparam int unsigned LMC_WAKE_FILT_US = 90;
  localparam int unsigned LMC_RST_DELAY_US = 10000;
  localparam int unsigned LMC_RST_FALL_CYC = 4;
  // Least times are the plain product of microseconds and clock MHz, no extra cycle
  localparam int unsigned LMC_DOM_LIMIT_CYC = LMC_DOM_LIMIT_US * LMC_CLK_MHZ;
  localparam int unsigned LMC_DOM_CLEAR_CYC = LMC_DOM_CLEAR_US * LMC_CLK_MHZ;
  localparam int unsigned LMC_WAKE_FILT_CYC = LMC_WAKE_FILT_US * LMC_CLK_MHZ;
  localparam int unsigned LMC_RST_DELAY_CYC = LMC_RST_DELAY_US * LMC_CLK_MHZ;
endpackage

// ===== verilog/lmc_timer.sv
/*
  Saturating qualification timer: done once run has held for LIMIT cycles.
  Assumes run is a registered level on the same clock.
*/
`timescale 1ns/1ns
module lmc_timer #(
  parameter int unsigned LIMIT = 16,
  parameter int unsigned W = 24
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Control
  input wire logic run_in,
  output logic done_out
);
  logic [W-1:0] cnt_q;

  // Refuse a limit the counter cannot reach
  if (LIMIT < 1 || LIMIT >= (64'd1 << W)) begin : g_bad_limit
    $error("lmc_timer limit out of range");
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in || !run_in) begin
      cnt_q <= '0;
    end else if (cnt_q != W'(LIMIT)) begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  assign done_out = (cnt_q == W'(LIMIT));
endmodule

// ===== tb/lmc_bus_model.sv
/*
  Bus line model: the far-side node sharing the single wire.
  Assumes the device driver and remote node act on clk_sys_in.
*/
`timescale 1ns/1ns
module lmc_bus_model (
  // Clock
  input wire logic clk_sys_in,
  // Device driver and remote node
  input wire logic drive_in,
  input wire logic wake_in,
  output logic bus_dominant_out
);
  // =====
  // Wired line
  // Any driver wins: recessive only when nobody pulls
  always_ff @(posedge clk_sys_in) begin
    bus_dominant_out <= drive_in | wake_in;
  end
endmodule

// ===== tb/lin_transceiver_mode_control_tb.sv
/*
  Bench of the mode control: modes, time-out, wake-up, reset output.
  Assumes shortened counts; checks leave room for input sync latency.
*/
`timescale 1ns/1ns
module lin_transceiver_mode_control_tb;
  logic clk_sys_in = 0, rst_in = 1, mode_sel_in = 0, txd_in = 1;
  logic wake_in = 0, vcc_under_in = 0, battery_supply_low_in = 0;
  logic bus_dominant_in, rxd_out, supply_fail_reset_out;
  logic bus_drive_out, termination_on_out, regulator_on_out;
  logic dom_timeout_out;
  lmc_pkg::lmc_mode_t mode_out;
  int errors = 0, check_count = 0, seed = 32'hb1530c85;
  localparam int RST = 50;
  // =====
  // Clock, design, bus
  initial forever #4 clk_sys_in = ~clk_sys_in;
  lmc_ctrl #(.DOM_LIMIT_CYC(40), .DOM_CLEAR_CYC(10),
    .WAKE_FILT_CYC(20), .RST_DELAY_CYC(RST)) u_lmc_ctrl (
    .clk_sys_in, .rst_in, .mode_sel_in, .txd_in, .rxd_out,
    .supply_fail_reset_out, .bus_dominant_in, .bus_drive_out,
    .termination_on_out, .vcc_under_in, .battery_supply_low_in,
    .regulator_on_out, .dom_timeout_out, .mode_out);
  lmc_bus_model u_lmc_bus_model (.clk_sys_in, .drive_in(bus_drive_out),
    .wake_in, .bus_dominant_out(bus_dominant_in));
  // =====
  // Helpers
  // Settle one step past the edge so updates have landed
  task automatic w(int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic chk(logic [3:0] got, logic [3:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic lmc_pkg::lmc_mode_t on_fall(logic txd);
    return txd ? lmc_pkg::LMC_SILENT : lmc_pkg::LMC_SLEEP;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // =====
  // Watchdog: run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk_sys_in);
    errors++;
    report_and_stop();
  end
  // =====
  // Scenarios
  initial begin
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 0;
    w(5);
    chk({mode_out, supply_fail_reset_out}, 3'b000);
    w(RST + 10);
    chk(supply_fail_reset_out, 1);
    mode_sel_in <= 1;
    w(6);
    chk(mode_out, lmc_pkg::LMC_NORMAL);
    // Forced high every fourth step keeps lows short of the limit
    for (int i = 0; i < 30; i++) begin
      txd_in <= (i % 4 == 3) | $random(seed);
      w(6);
      chk(bus_drive_out, !txd_in);
      chk(rxd_out, !bus_dominant_in);
    end
    txd_in <= 0;
    battery_supply_low_in <= 1;
    w(6);
    chk(bus_drive_out, 0);
    battery_supply_low_in <= 0;
    w(48);
    chk({dom_timeout_out, bus_drive_out}, 2'b10);
    txd_in <= 1;
    w(5);
    chk(dom_timeout_out, 1);
    w(15);
    chk(dom_timeout_out, 0);
    mode_sel_in <= 0;
    w(6);
    chk({mode_out, termination_on_out}, {on_fall(1), 1'b0});
    txd_in <= 0;
    w(6);
    chk(bus_drive_out, 0);
    txd_in <= 1;
    wake_in <= 1;
    w(10);
    chk(mode_out, lmc_pkg::LMC_SILENT);
    w(20);
    chk({mode_out, rxd_out, termination_on_out}, 4'b0001);
    wake_in <= 0;
    mode_sel_in <= 1;
    w(6);
    chk(mode_out, lmc_pkg::LMC_NORMAL);
    vcc_under_in <= 1;
    w(8);
    chk({mode_out, supply_fail_reset_out}, 3'b000);
    vcc_under_in <= 0;
    w(10);
    chk(mode_out, lmc_pkg::LMC_PRENORMAL);
    w(RST + 10);
    chk({mode_out, supply_fail_reset_out}, 3'b011);
    txd_in <= 0;
    mode_sel_in <= 0;
    w(6);
    chk(mode_out, on_fall(0));
    chk({regulator_on_out, rxd_out, supply_fail_reset_out}, 0);
    txd_in <= 1;
    wake_in <= 1;
    w(30);
    chk(mode_out, lmc_pkg::LMC_PRENORMAL);
    report_and_stop();
  end
endmodule
